// >>> channel_divider.sv
// Module: output channel divider producing a one-cycle tick every ratio cycles
`timescale 1ns/1ps
`default_nettype none
module channel_divider
	import clock_config_pkg::*;
#(
	parameter int WIDTH = 8 // Ratio width
) (
	input wire logic clk_i, // System clock
	input wire logic reset_n_i, // Async reset, active low
	input wire logic [WIDTH-1:0] ratio_i, // Active divide ratio, zero stops
	input wire logic clear_i, // Restart counting
	output logic tick_o // One-cycle pulse per period
);

	// Ratio width must hold at least one bit
	if (WIDTH < 1) begin : width_check
		$error("channel_divider WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] count_reg; // Cycles since last tick
	logic [WIDTH-1:0] count_next; // Next count
	logic tick_reg; // Registered tick
	logic tick_next; // Next tick

	////////////////////////////////////////////////////////////////////////////////
	// Count and tick decision
	always_comb begin
		count_next = count_reg;
		tick_next = 1'b0;
		if (clear_i || ratio_i == '0) begin
			// Held static and restarted from zero, so a new ratio starts a clean period
			count_next = '0; // R9 R17
		end else if (count_reg >= ratio_i - WIDTH'(1)) begin
			// Compare with >= so a shrinking ratio never overruns
			count_next = '0; // R7 R8
			tick_next = 1'b1;
		end else begin
			count_next = count_reg + WIDTH'(1);
		end
	end

	// State registers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_o = tick_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	zero_ratio_stop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R9
		ratio_i == '0 |=> !tick_o && count_reg == '0)
		else $error("divider ticked with zero ratio");

	clear_restart_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
		clear_i |=> !tick_o && count_reg == '0)
		else $error("divider not restarted by clear");

	ratio_one_rate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R7
		ratio_i == WIDTH'(1) && !clear_i |=> tick_o)
		else $error("ratio one did not tick every cycle");

	// Full period after a tick: two quiet cycles, then the next tick
	ratio_three_gap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R8
		tick_o && ratio_i == WIDTH'(3) && !clear_i ##1 (ratio_i == WIDTH'(3) && !clear_i) [*2]
		|-> !tick_o && !$past(tick_o) ##1 tick_o)
		else $error("ratio three period wrong");

endmodule : channel_divider
`default_nettype wire

// >>> clock_config_bank.sv
// Module: reference input and output divider configuration bank with buffered update
//
// Overview of operation
// [R1] Host writes zero in reference one bits 7:4
// [R2] Host writes zero in reference two bits 7:4
// [R3] Reference one termination code bits 3:2, reset 01
// [R4] Reference two termination code bits 3:2, reset 01
// [R5] Reference one regulator and input enable, reset on
// [R6] Reference two regulator on, input off at reset
// [R7] Channel one divides by ratio, reset one
// [R8] Channel two divides by ratio, reset one
// [R9] Zero ratio disables the channel divider
// [R10] Host writes zero in driver bits 7:6
// [R11] Channel one swing trim bits 5:4, reset 10
// [R12] Channel one termination bit 3, reset off
// [R13] Regulator bit 2 on, output bit 1 off
// [R14] Bit 0 write clears channel one divider, self-clears
// [R15] Divider clear acts without the update strobe
// [R16] Writes buffered, copied to active on update
// [R17] Disabled divider output static, restarts cleanly
`timescale 1ns/1ps
`default_nettype none
module clock_config_bank
	import clock_config_pkg::*;
(
	input wire logic clk_i, // System clock, 200 MHz
	input wire logic reset_n_i, // Async reset, active low
	input wire logic wr_en_i, // Register write strobe
	input wire logic rd_en_i, // Register read strobe
	input wire logic [ADDR_W-1:0] addr_i, // Register address
	input wire logic [DATA_W-1:0] wdata_i, // Write data
	output logic [DATA_W-1:0] rdata_o, // Read data, valid with rvalid_o
	output logic rvalid_o, // Read answer pulse
	output ref_cfg_s ref_one_o, // Active reference one settings
	output ref_cfg_s ref_two_o, // Active reference two settings
	output drv_cfg_s ch_one_drv_o, // Active channel one driver settings
	output logic [DATA_W-1:0] ch_one_ratio_o, // Active channel one ratio
	output logic [DATA_W-1:0] ch_two_ratio_o, // Active channel two ratio
	output logic ch_one_tick_o, // Channel one divided tick
	output logic ch_two_tick_o // Channel two divided tick
);

	////////////////////////////////////////////////////////////////////////////////
	// Buffer and active state
	ref_cfg_s ref_one_buf_reg, ref_one_buf_next; // Host-facing copy
	ref_cfg_s ref_two_buf_reg, ref_two_buf_next; // Host-facing copy
	drv_cfg_s drv_buf_reg, drv_buf_next; // Host-facing copy
	logic [DATA_W-1:0] ratio_one_buf_reg, ratio_one_buf_next; // Host-facing copy
	logic [DATA_W-1:0] ratio_two_buf_reg, ratio_two_buf_next; // Host-facing copy
	ref_cfg_s ref_one_reg, ref_one_next; // Active copy
	ref_cfg_s ref_two_reg, ref_two_next; // Active copy
	drv_cfg_s drv_reg, drv_next; // Active copy
	logic [DATA_W-1:0] ratio_one_reg, ratio_one_next; // Active copy
	logic [DATA_W-1:0] ratio_two_reg, ratio_two_next; // Active copy
	logic clear_reg, clear_next; // Live divider clear pulse
	logic [DATA_W-1:0] rdata_reg, rdata_next; // Read answer
	logic rvalid_reg, rvalid_next; // Read answer valid
	logic update; // Transfer strobe this cycle

	////////////////////////////////////////////////////////////////////////////////
	// Write decode into buffers and live bits
	always_comb begin
		ref_one_buf_next = ref_one_buf_reg;
		ref_two_buf_next = ref_two_buf_reg;
		drv_buf_next = drv_buf_reg;
		ratio_one_buf_next = ratio_one_buf_reg;
		ratio_two_buf_next = ratio_two_buf_reg;
		clear_next = 1'b0; // Self-clearing after one cycle
		update = 1'b0;
		if (wr_en_i) begin
			case (addr_i)
				// Upper bits are the host's to keep zero; they are not stored
				REF_ONE_OFFSET: begin
					ref_one_buf_next = ref_cfg_s'(wdata_i[REF_FIELD_MSB:0]); // R3 R5
				end
				REF_TWO_OFFSET: begin
					ref_two_buf_next = ref_cfg_s'(wdata_i[REF_FIELD_MSB:0]); // R4 R6
				end
				CH_ONE_RATIO_OFFSET: begin
					ratio_one_buf_next = wdata_i; // R7
				end
				CH_ONE_DRV_OFFSET: begin
					drv_buf_next = drv_cfg_s'(wdata_i[DRV_FIELD_MSB:DRV_FIELD_LSB]); // R11 R12 R13
					clear_next = wdata_i[CLEAR_BIT]; // R14 R15
				end
				CH_TWO_RATIO_OFFSET: begin
					ratio_two_buf_next = wdata_i; // R8
				end
				UPDATE_OFFSET: begin
					update = wdata_i[UPDATE_BIT]; // R16
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer to active copy on strobe only
	always_comb begin
		ref_one_next = ref_one_reg;
		ref_two_next = ref_two_reg;
		drv_next = drv_reg;
		ratio_one_next = ratio_one_reg;
		ratio_two_next = ratio_two_reg;
		if (update) begin
			// Strobe and a buffer write never share a cycle: one address per access
			ref_one_next = ref_one_buf_reg; // R16
			ref_two_next = ref_two_buf_reg;
			drv_next = drv_buf_reg;
			ratio_one_next = ratio_one_buf_reg;
			ratio_two_next = ratio_two_buf_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path; readback shows buffers, live bits and reserved bits read zero
	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = rd_en_i;
		if (rd_en_i) begin
			case (addr_i)
				REF_ONE_OFFSET: rdata_next = DATA_W'(ref_one_buf_reg);
				REF_TWO_OFFSET: rdata_next = DATA_W'(ref_two_buf_reg);
				CH_ONE_RATIO_OFFSET: rdata_next = ratio_one_buf_reg;
				CH_ONE_DRV_OFFSET: rdata_next = DATA_W'({drv_buf_reg, 1'b0});
				CH_TWO_RATIO_OFFSET: rdata_next = ratio_two_buf_reg;
				default: rdata_next = READ_NONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State registers, reset to the documented defaults
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ref_one_buf_reg <= ref_cfg_s'(REF_ONE_RESET[REF_FIELD_MSB:0]); // R3 R5
			ref_two_buf_reg <= ref_cfg_s'(REF_TWO_RESET[REF_FIELD_MSB:0]); // R4 R6
			drv_buf_reg <= drv_cfg_s'(DRV_RESET[DRV_FIELD_MSB:DRV_FIELD_LSB]); // R11 R12 R13
			ratio_one_buf_reg <= RATIO_RESET;
			ratio_two_buf_reg <= RATIO_RESET;
			ref_one_reg <= ref_cfg_s'(REF_ONE_RESET[REF_FIELD_MSB:0]);
			ref_two_reg <= ref_cfg_s'(REF_TWO_RESET[REF_FIELD_MSB:0]);
			drv_reg <= drv_cfg_s'(DRV_RESET[DRV_FIELD_MSB:DRV_FIELD_LSB]);
			ratio_one_reg <= RATIO_RESET; // R7
			ratio_two_reg <= RATIO_RESET; // R8
			clear_reg <= 1'b0;
			rdata_reg <= READ_NONE;
			rvalid_reg <= 1'b0;
		end else begin
			ref_one_buf_reg <= ref_one_buf_next;
			ref_two_buf_reg <= ref_two_buf_next;
			drv_buf_reg <= drv_buf_next;
			ratio_one_buf_reg <= ratio_one_buf_next;
			ratio_two_buf_reg <= ratio_two_buf_next;
			ref_one_reg <= ref_one_next;
			ref_two_reg <= ref_two_next;
			drv_reg <= drv_next;
			ratio_one_reg <= ratio_one_next;
			ratio_two_reg <= ratio_two_next;
			clear_reg <= clear_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel dividers; only channel one has a live clear in this bank
	localparam int CHANNELS = 2; // Dividers in this bank
	logic [CHANNELS-1:0][DATA_W-1:0] div_ratio; // Active ratio per channel
	logic [CHANNELS-1:0] div_clear; // Live clear per channel
	logic [CHANNELS-1:0] div_tick; // Tick per channel

	assign div_ratio = {ratio_two_reg, ratio_one_reg};
	// Channel two's clear lives in a register outside this bank, so it stays low
	assign div_clear = {1'b0, clear_reg}; // R14

	for (genvar ch = 0; ch < CHANNELS; ch++) begin : div_gen
		channel_divider #(.WIDTH(DATA_W)) div (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.ratio_i(div_ratio[ch]),
			.clear_i(div_clear[ch]),
			.tick_o(div_tick[ch])
		);
	end

	assign ch_one_tick_o = div_tick[0];
	assign ch_two_tick_o = div_tick[1];

	assign rdata_o = rdata_reg;
	assign rvalid_o = rvalid_reg;
	assign ref_one_o = ref_one_reg;
	assign ref_two_o = ref_two_reg;
	assign ch_one_drv_o = drv_reg;
	assign ch_one_ratio_o = ratio_one_reg;
	assign ch_two_ratio_o = ratio_two_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking chk_cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence update_write_s;
		wr_en_i && addr_i == UPDATE_OFFSET && wdata_i[UPDATE_BIT];
	endsequence

	sequence clear_write_s;
		wr_en_i && addr_i == CH_ONE_DRV_OFFSET && wdata_i[CLEAR_BIT];
	endsequence

	update_copies_a: assert property (update_write_s |=> // R16
		ratio_one_reg == $past(ratio_one_buf_reg) && drv_reg == $past(drv_buf_reg))
		else $error("update did not copy buffers");

	hold_active_a: assert property (!update |=> $stable(ratio_two_reg) && $stable(ref_two_reg)) // R16
		else $error("active copy changed without update");

	live_clear_a: assert property (clear_write_s |=> clear_reg ##1 ch_one_tick_o == 1'b0) // R15
		else $error("divider clear not live");

	clear_self_ends_a: assert property (clear_reg && !clear_write_s |=> !clear_reg) // R14
		else $error("divider clear did not self-clear");

	ref_readback_a: assert property (rd_en_i && addr_i == REF_ONE_OFFSET |=> // R3
		rvalid_o && rdata_o == DATA_W'($past(ref_one_buf_reg)))
		else $error("reference one readback wrong");

	drv_read_zero_a: assert property (rd_en_i && addr_i == CH_ONE_DRV_OFFSET |=> // R10 R14
		rdata_o[CLEAR_BIT] == 1'b0 && rdata_o[DATA_W-1:DRV_FIELD_MSB+1] == '0)
		else $error("driver live or reserved bits read nonzero");

	ratio_zero_static_a: assert property ((ratio_one_reg == RATIO_OFF) [*2] |=> !ch_one_tick_o) // R9 R17
		else $error("disabled channel one ticked");

	trim_follow_a: assert property (update_write_s ##1 !update [*2] |-> // R11
		ch_one_drv_o.swing_trim == $past(drv_buf_reg.swing_trim, 2))
		else $error("swing trim did not follow update");

endmodule : clock_config_bank
`default_nettype wire

// >>> clock_config_pkg.sv
// Package: register map, field layout, reset values and carriers for the clock config bank
`default_nettype none
package clock_config_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register port geometry
	localparam int ADDR_W = 12; // Register address width
	localparam int DATA_W = 8; // Register data width

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [ADDR_W-1:0] UPDATE_OFFSET = 12'h00F; // Transfer strobe
	localparam logic [ADDR_W-1:0] REF_ONE_OFFSET = 12'h012; // reference_one_control
	localparam logic [ADDR_W-1:0] REF_TWO_OFFSET = 12'h013; // reference_two_control
	localparam logic [ADDR_W-1:0] CH_ONE_RATIO_OFFSET = 12'h014; // channel_one_divide_ratio
	localparam logic [ADDR_W-1:0] CH_ONE_DRV_OFFSET = 12'h015; // channel_one_driver_control
	localparam logic [ADDR_W-1:0] CH_TWO_RATIO_OFFSET = 12'h016; // channel_two_divide_ratio

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int REF_FIELD_MSB = 3; // Reference fields occupy [3:0]
	localparam int DRV_FIELD_MSB = 5; // Driver fields occupy [5:1]
	localparam int DRV_FIELD_LSB = 1; // Lowest stored driver bit
	localparam int CLEAR_BIT = 0; // Live divider clear
	localparam int UPDATE_BIT = 0; // Live transfer strobe

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, full register bytes
	localparam logic [DATA_W-1:0] REF_ONE_RESET = 8'h07; // Term 01, regulator on, input on
	localparam logic [DATA_W-1:0] REF_TWO_RESET = 8'h06; // Term 01, regulator on, input off
	localparam logic [DATA_W-1:0] RATIO_RESET = 8'h01; // Divide by one
	localparam logic [DATA_W-1:0] DRV_RESET = 8'h24; // Trim 10, regulator on, rest off
	localparam logic [DATA_W-1:0] RATIO_OFF = 8'h00; // Ratio that stops a divider
	localparam logic [DATA_W-1:0] READ_NONE = 8'h00; // Answer for unmapped reads

	////////////////////////////////////////////////////////////////////////////////
	// Carriers; packing order equals register bit order
	typedef struct packed {
		logic [1:0] termination_code; // 00 100R diff, 01 50R gnd, 10 AC bias, 11 high-Z
		logic regulator_on; // Input regulator enable
		logic input_on; // Input enable
	} ref_cfg_s;

	typedef struct packed {
		logic [1:0] swing_trim; // 00 0.8V, 01 0.9V, 10 1.0V, 11 1.1V
		logic termination_on; // On-chip termination
		logic regulator_on; // Driver regulator enable
		logic output_on; // Output enable
	} drv_cfg_s;

endpackage : clock_config_pkg
`default_nettype wire

// >>> config_host.sv
// Host model that drives the configuration register port of the bank
`timescale 1ns/1ps
`default_nettype none
module config_host
	import clock_config_pkg::*;
(
	input wire logic clk_i, // System clock
	output logic wr_en_o, // Write strobe
	output logic rd_en_o, // Read strobe
	output logic [ADDR_W-1:0] addr_o, // Register address
	output logic [DATA_W-1:0] wdata_o, // Write data
	input wire logic [DATA_W-1:0] rdata_i, // Read data
	input wire logic rvalid_i // Read answer pulse
);
	// Idle bus at time zero
	initial begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		addr_o = 12'hFFF;
		wdata_o = 8'hFF;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One write; a real host never sets reserved bits, so neither do we
	task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] v;
		v = d;
		if (a == REF_ONE_OFFSET || a == REF_TWO_OFFSET) v[7:4] = 4'h0;
		if (a == CH_ONE_DRV_OFFSET) v[7:6] = 2'h0;
		if (a == UPDATE_OFFSET) v[7:1] = 7'h00;
		@(posedge clk_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		@(posedge clk_i);
		// Released lines show inverted values so stale data never looks valid
		wr_en_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~v;
	endtask : write_reg

	// One read; answer taken 1 ns after the taking edge
	task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
		output logic v);
		@(posedge clk_i);
		rd_en_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_en_o <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
		v = rvalid_i;
	endtask : read_reg
endmodule : config_host
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the clock configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb
	import clock_config_pkg::*;
;
	logic clk_i = 1'b0; // System clock
	logic reset_n_i; // Async reset, active low
	logic wr_en, rd_en, rvalid, t1, t2, v; // Port strobes and ticks
	logic [ADDR_W-1:0] addr; // Register address
	logic [DATA_W-1:0] wdata, rdata, r1, r2, rd; // Data and active ratios
	ref_cfg_s ref_one, ref_two; // Active reference settings
	drv_cfg_s drv; // Active driver settings
	int errors = 0; // Mismatch count
	int tests_run = 0; // Comparison count
	int cycles = 0; // Timeout counter
	int c1, c2, first; // Tick counts and cycle of first tick
	integer seed = 32'h7edebdfe; // Fixed seed
	logic [DATA_W-1:0] b, n1, n2; // Random scratch
	logic [ADDR_W-1:0] regs [5] = '{12'h012, 12'h013, 12'h014, 12'h015, 12'h016};
	logic [DATA_W-1:0] cur [5] = '{8'h07, 8'h06, 8'h01, 8'h24, 8'h01}; // Expected buffers
	logic [DATA_W-1:0] nw [5]; // New values

	always #2.5 clk_i = ~clk_i;

	clock_config_bank dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en),
		.rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
		.ref_one_o(ref_one), .ref_two_o(ref_two), .ch_one_drv_o(drv), .ch_one_ratio_o(r1),
		.ch_two_ratio_o(r2), .ch_one_tick_o(t1), .ch_two_tick_o(t2));
	config_host host (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
		.wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));

	////////////////////////////////////////////////////////////////////////////////
	// Hang guard; the full run needs well under this
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			stop_test();
		end
	end

	// Byte compare
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Readback model: reserved and live bits read zero, unmapped reads zero
	function automatic logic [7:0] stored(input logic [11:0] a, input logic [7:0] d);
		case (a)
			REF_ONE_OFFSET, REF_TWO_OFFSET: return d & 8'h0F;
			CH_ONE_DRV_OFFSET: return d & 8'h3E;
			CH_ONE_RATIO_OFFSET, CH_TWO_RATIO_OFFSET: return d;
			default: return 8'h00;
		endcase
	endfunction : stored

	// Write, read back, expect buffered value with an answer pulse
	task automatic wr_rd(input logic [11:0] a, input logic [7:0] d);
		host.write_reg(a, d);
		host.read_reg(a, rd, v);
		check(rd, stored(a, d));
		check({7'h00, v}, 8'h01);
		// Answer pulse lasts one cycle only
		@(posedge clk_i);
		#1;
		check({7'h00, rvalid}, 8'h00);
	endtask : wr_rd

	// Active outputs against expected buffer bytes
	task automatic act(input logic [7:0] e [5]);
		check({4'h0, ref_one}, e[0] & 8'h0F);
		check({4'h0, ref_two}, e[1] & 8'h0F);
		check(r1, e[2]);
		check({3'h0, drv}, (e[3] >> 1) & 8'h1F);
		check(r2, e[4]);
	endtask : act

	// Count ticks of both channels over n cycles
	task automatic count(input int n);
		c1 = 0;
		c2 = 0;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			if (t1 === 1'b1) c1++;
			if (t2 === 1'b1) c2++;
		end
	endtask : count

	// Set both ratios and make them active
	task automatic ratios(input logic [7:0] a, input logic [7:0] c);
		host.write_reg(CH_ONE_RATIO_OFFSET, a);
		host.write_reg(CH_TWO_RATIO_OFFSET, c);
		host.write_reg(UPDATE_OFFSET, 8'h01);
		#1;
		check(r1, a);
		check(r2, c);
	endtask : ratios

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset_n_i = 1'b0;
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		#1;
		act(cur);
		for (int i = 0; i < 5; i++) begin
			host.read_reg(regs[i], rd, v);
			check(rd, cur[i]);
		end
		count(8);
		check(8'(c1), 8'd8);
		check(8'(c2), 8'd8);
		$display("test reset values done");
		// Every code of the termination and trim fields, buffered until the strobe
		for (int i = 0; i < 4; i++) begin
			b = $random(seed);
			nw = '{{b[7:4], 2'(i), b[1:0]}, {b[3:0], 2'(3 - i), b[5:4]}, 8'($random(seed)),
				{b[7:6], 2'(i), b[4:2], 1'b0}, 8'($random(seed))};
			for (int j = 0; j < 5; j++) wr_rd(regs[j], nw[j]);
			act(cur);
			host.write_reg(UPDATE_OFFSET, 8'h01);
			#1;
			cur = nw;
			act(cur);
		end
		$display("test field codes done");
		// Divide ratios: corners then random
		for (int i = 0; i < 8; i++) begin
			n1 = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : (i == 2) ? 8'h02 : 8'($random(seed));
			if (n1 == 8'h00) n1 = 8'h03;
			n2 = 8'(9'h100 - n1);
			ratios(n1, n2);
			repeat (300) @(posedge clk_i);
			count(4 * n1);
			check(8'(c1), 8'd4);
			count(4 * n2);
			check(8'(c2), 8'd4);
		end
		$display("test divide ratios done");
		// Zero ratio stops both dividers, then a restart
		ratios(8'h00, 8'h00);
		count(300);
		check(8'(c1), 8'd0);
		check(8'(c2), 8'd0);
		ratios(8'h03, 8'h03);
		count(12);
		check(8'(c1), 8'd4);
		check(8'(c2), 8'd4);
		$display("test zero ratio done");
		// Live divider clear without any update strobe
		ratios(8'h07, 8'h07);
		repeat (3) @(posedge clk_i);
		host.write_reg(CH_ONE_DRV_OFFSET, 8'h3F);
		first = 0;
		for (int k = 1; k <= 9; k++) begin
			@(posedge clk_i);
			#1;
			if (k >= 2 && first == 0 && t1 === 1'b1) first = k;
		end
		check(8'(first), 8'd8);
		check({3'h0, drv}, (cur[3] >> 1) & 8'h1F);
		host.read_reg(CH_ONE_DRV_OFFSET, rd, v);
		check(rd, 8'h3E);
		host.write_reg(UPDATE_OFFSET, 8'h01);
		#1;
		check({3'h0, drv}, 8'h1F);
		$display("test divider clear done");
		// Unmapped and strobe addresses read zero
		wr_rd(12'h011, 8'hFF);
		wr_rd(12'h020, 8'hA5);
		host.read_reg(UPDATE_OFFSET, rd, v);
		check(rd, 8'h00);
		$display("test unmapped done");
		stop_test();
	end
endmodule : tb
`default_nettype wire
